// file: verilog/cell_input_select.v
`timescale 1ns/1ps
`default_nettype none
`include "cell_input_map.vh"

module cell_input_select #(
    parameter NUM_SOURCES = 32
) (
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire [NUM_SOURCES-1:0] source_in,
    output wire input_one_data,
    output wire input_two_data,
    output wire input_three_data,
    output wire input_four_data,
    output reg first_gate_output,
    output reg first_gate_to_core
);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    reg [`SRC_CODE_MSB:0] input_one_source_code_q;
    reg [`SRC_CODE_MSB:0] input_two_source_code_q;
    reg [`SRC_CODE_MSB:0] input_three_source_code_q;
    reg [`SRC_CODE_MSB:0] input_four_source_code_q;
    reg [`REG_W-1:0] gate1_input_enable_q;
    reg gate_one_invert_bit_q;

    // ------------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------------
    reg [NUM_SOURCES-1:0] source_meta_q;
    reg [NUM_SOURCES-1:0] source_sync_q;

    // ------------------------------------------------------------------
    // Bus decode signals
    // ------------------------------------------------------------------
    wire setup_phase;
    wire write_access;
    wire low_lane;
    reg addr_mapped;
    reg [`REG_W-1:0] read_value;

    wire [3:0] data_true;
    wire [3:0] data_inverted;
    wire [`REG_W-1:0] gate_terms;
    wire gate1_d;

    // ------------------------------------------------------------------
    // Synchronise the raw sources
    // ------------------------------------------------------------------
    // The sources arrive from pins and other clock domains, so every bit
    // passes two flops before any selector sees it.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            source_meta_q <= {NUM_SOURCES{1'b0}};
            source_sync_q <= {NUM_SOURCES{1'b0}};
        end else begin
            source_meta_q <= source_in;
            source_sync_q <= source_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Four data input selectors
    // ------------------------------------------------------------------
    source_mux #(
        .NUM_SOURCES(NUM_SOURCES),
        .CODE_W(`SRC_CODE_W)
    ) u_sel_one (
        .mclk(mclk),
        .rst_n(rst_n),
        .sources(source_sync_q),
        .code(input_one_source_code_q),
        .selected_q(input_one_data)
    );

    source_mux #(
        .NUM_SOURCES(NUM_SOURCES),
        .CODE_W(`SRC_CODE_W)
    ) u_sel_two (
        .mclk(mclk),
        .rst_n(rst_n),
        .sources(source_sync_q),
        .code(input_two_source_code_q),
        .selected_q(input_two_data)
    );

    source_mux #(
        .NUM_SOURCES(NUM_SOURCES),
        .CODE_W(`SRC_CODE_W)
    ) u_sel_three (
        .mclk(mclk),
        .rst_n(rst_n),
        .sources(source_sync_q),
        .code(input_three_source_code_q),
        .selected_q(input_three_data)
    );

    source_mux #(
        .NUM_SOURCES(NUM_SOURCES),
        .CODE_W(`SRC_CODE_W)
    ) u_sel_four (
        .mclk(mclk),
        .rst_n(rst_n),
        .sources(source_sync_q),
        .code(input_four_source_code_q),
        .selected_q(input_four_data)
    );

    // ------------------------------------------------------------------
    // First gate
    // ------------------------------------------------------------------
    assign data_true = {input_four_data, input_three_data,
                        input_two_data, input_one_data};
    assign data_inverted = ~data_true;

    // Enable bit 2k+1 admits data input k+1 true, bit 2k admits it inverted.
    assign gate_terms = {data_true[3], data_inverted[3],
                         data_true[2], data_inverted[2],
                         data_true[1], data_inverted[1],
                         data_true[0], data_inverted[0]}
                        & gate1_input_enable_q;

    // With every enable clear the gate output rests low.
    assign gate1_d = |gate_terms;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_gate_output <= 1'b0;
            first_gate_to_core <= 1'b0;
        end else begin
            first_gate_output <= gate1_d;
            first_gate_to_core <= gate1_d ^ gate_one_invert_bit_q;
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // The slave never inserts wait states: read data and the error flag
    // are captured at the setup edge, so the access phase can end at once.
    assign pready = 1'b1;
    assign setup_phase = psel & ~penable;
    assign low_lane = pstrb[0];
    assign write_access = psel & penable & pwrite & addr_mapped;

    always @* begin
        addr_mapped = 1'b1;
        read_value = {`REG_W{1'b0}};
        if (paddr == `OFS_DATA1_SOURCE_SELECT) begin
            read_value = {3'h0, input_one_source_code_q};
        end else if (paddr == `OFS_DATA2_SOURCE_SELECT) begin
            read_value = {3'h0, input_two_source_code_q};
        end else if (paddr == `OFS_DATA3_SOURCE_SELECT) begin
            read_value = {3'h0, input_three_source_code_q};
        end else if (paddr == `OFS_DATA4_SOURCE_SELECT) begin
            read_value = {3'h0, input_four_source_code_q};
        end else if (paddr == `OFS_GATE1_INPUT_ENABLE) begin
            read_value = gate1_input_enable_q;
        end else if (paddr == `OFS_GATE_POLARITY) begin
            read_value = {7'h00, gate_one_invert_bit_q};
        end else if (paddr == `OFS_CELL_STATUS) begin
            read_value = {2'h0, first_gate_to_core, first_gate_output,
                          input_four_data, input_three_data,
                          input_two_data, input_one_data};
        end else begin
            addr_mapped = 1'b0;
        end
    end

    // Writes to the read-only status word are refused with an error.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata <= {24'h00_0000, read_value};
            pslverr <= ~addr_mapped
                       | (pwrite & (paddr == `OFS_CELL_STATUS));
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Only the low byte lane holds state; upper lanes are accepted and
    // dropped. The asynchronous reset stands for power-on, where the
    // fields are otherwise undefined; no other reset touches them.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_one_source_code_q <= `RST_SRC_CODE;
        end else if (write_access && low_lane &&
                     paddr == `OFS_DATA1_SOURCE_SELECT) begin
            input_one_source_code_q <= pwdata[`SRC_CODE_MSB:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_two_source_code_q <= `RST_SRC_CODE;
        end else if (write_access && low_lane &&
                     paddr == `OFS_DATA2_SOURCE_SELECT) begin
            input_two_source_code_q <= pwdata[`SRC_CODE_MSB:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_three_source_code_q <= `RST_SRC_CODE;
        end else if (write_access && low_lane &&
                     paddr == `OFS_DATA3_SOURCE_SELECT) begin
            input_three_source_code_q <= pwdata[`SRC_CODE_MSB:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_four_source_code_q <= `RST_SRC_CODE;
        end else if (write_access && low_lane &&
                     paddr == `OFS_DATA4_SOURCE_SELECT) begin
            input_four_source_code_q <= pwdata[`SRC_CODE_MSB:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate1_input_enable_q <= `RST_GATE1_ENABLE;
        end else if (write_access && low_lane &&
                     paddr == `OFS_GATE1_INPUT_ENABLE) begin
            gate1_input_enable_q <= pwdata[`REG_W-1:0];
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_one_invert_bit_q <= `RST_GATE_POLARITY;
        end else if (write_access && low_lane &&
                     paddr == `OFS_GATE_POLARITY) begin
            gate_one_invert_bit_q <= pwdata[`GATE1_POL_BIT];
        end
    end

endmodule // cell_input_select

`default_nettype wire

// file: verilog/cell_input_map.vh
`ifndef CELL_INPUT_MAP_VH
`define CELL_INPUT_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_DATA1_SOURCE_SELECT 12'h000
`define OFS_DATA2_SOURCE_SELECT 12'h004
`define OFS_DATA3_SOURCE_SELECT 12'h008
`define OFS_DATA4_SOURCE_SELECT 12'h00c
`define OFS_GATE1_INPUT_ENABLE 12'h010
`define OFS_GATE_POLARITY 12'h014
`define OFS_CELL_STATUS 12'h018

// ----------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------
`define SRC_CODE_W 5
`define SRC_CODE_MSB 4
`define REG_W 8
`define GATE1_POL_BIT 0
`define STAT_GATE1_BIT 4
`define STAT_GATE1_POL_BIT 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SRC_CODE 5'h00
`define RST_GATE1_ENABLE 8'h00
`define RST_GATE_POLARITY 1'h0

`endif

// file: verilog/source_mux.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// One source selector with a registered output
// ----------------------------------------------------------------------
module source_mux #(
    parameter NUM_SOURCES = 32,
    parameter CODE_W = 5
) (
    input wire mclk,
    input wire rst_n,
    input wire [NUM_SOURCES-1:0] sources,
    input wire [CODE_W-1:0] code,
    output reg selected_q
);

    reg selected_d;

    // Codes past the last source select a constant low.
    always @* begin
        if (code < NUM_SOURCES) begin
            selected_d = sources[code];
        end else begin
            selected_d = 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            selected_q <= 1'b0;
        end else begin
            selected_q <= selected_d;
        end
    end

endmodule // source_mux

`default_nettype wire

// file: verif/cell_input_select_props.sv
`timescale 1ns/1ps
`default_nettype none
module cell_input_select_props #(
    parameter NUM_SOURCES = 32
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [NUM_SOURCES-1:0] source_in,
    input wire logic input_one_data,
    input wire logic input_two_data,
    input wire logic input_three_data,
    input wire logic input_four_data,
    input wire logic first_gate_output,
    input wire logic first_gate_to_core
);
    // Shadow of the config; data and gate checks wait until writes and sources settle.
    logic [7:0] cfg_q [0:5];
    logic [NUM_SOURCES-1:0] src_q;
    logic [2:0] quiet_q;
    logic map_ok, wr_hit, rd_acc, gate_d;
    assign map_ok = paddr < 12'h018 && paddr[1:0] == 2'h0;
    assign wr_hit = psel && penable && pwrite && pstrb[0] && map_ok;
    assign rd_acc = psel && penable && !pwrite && map_ok;
    assign gate_d = |(cfg_q[4] & {input_four_data, ~input_four_data,
        input_three_data, ~input_three_data, input_two_data,
        ~input_two_data, input_one_data, ~input_one_data});
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 6; i++) cfg_q[i] <= 8'h00;
            src_q <= '0;
            quiet_q <= 3'h0;
        end else begin
            src_q <= source_in;
            if (wr_hit) cfg_q[paddr[4:2]] <= pwdata[7:0] & (paddr[4] ?
                (paddr[2] ? 8'h01 : 8'hff) : 8'h1f);
            if (wr_hit || source_in != src_q) quiet_q <= 3'h0;
            else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // The counter lags a source change by one edge, so that edge itself
    // is excluded by comparing the source with its delayed copy.
    data_one_a: assert property (
        quiet_q > 3'h3 && source_in == src_q
            |-> input_one_data == source_in[cfg_q[0][4:0]])
        else $error("data input one wrong");
    data_two_a: assert property (
        quiet_q > 3'h3 && source_in == src_q
            |-> input_two_data == source_in[cfg_q[1][4:0]])
        else $error("data input two wrong");
    data_three_a: assert property (
        quiet_q > 3'h3 && source_in == src_q
            |-> input_three_data == source_in[cfg_q[2][4:0]])
        else $error("data input three wrong");
    data_four_a: assert property (
        quiet_q > 3'h3 && source_in == src_q
            |-> input_four_data == source_in[cfg_q[3][4:0]])
        else $error("data input four wrong");
    upper_zero_a: assert property (
        rd_acc |-> prdata[31:8] == 24'h0 && (paddr[4] || prdata[7:5] == 3'h0))
        else $error("unused bits read nonzero");
    read_back_a: assert property (
        rd_acc |-> prdata[7:0] == cfg_q[paddr[4:2]])
        else $error("register read back wrong");
    gate_one_a: assert property (
        quiet_q > 3'h4 |-> first_gate_output == gate_d)
        else $error("gate one output wrong");
    gate_pol_a: assert property (
        quiet_q > 3'h4 |-> first_gate_to_core == (gate_d ^ cfg_q[5][0]))
        else $error("gate one polarity wrong");
endmodule // cell_input_select_props
bind cell_input_select cell_input_select_props #(
    .NUM_SOURCES(NUM_SOURCES)) props_i (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .source_in(source_in),
    .input_one_data(input_one_data), .input_two_data(input_two_data),
    .input_three_data(input_three_data),
    .input_four_data(input_four_data),
    .first_gate_output(first_gate_output),
    .first_gate_to_core(first_gate_to_core));
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, src, w, rd;
    logic [3:0] pstrb;
    logic [31:0] source_in;
    logic d1, d2, d3, d4, g_out, g_core, er, pol, ex;
    logic [7:0] gen;
    logic [4:0] code [0:3];
    integer seed = 90325;
    int n_fail = 0;
    int checks_done = 0;
    cell_input_select #(.NUM_SOURCES(32)) DUT (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .source_in(source_in), .input_one_data(d1),
        .input_two_data(d2), .input_three_data(d3), .input_four_data(d4),
        .first_gate_output(g_out), .first_gate_to_core(g_core));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits an edge first so a release never meets the next request.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    function automatic logic gate_of(input logic [7:0] en,
        input logic [3:0] d);
        return |(en & {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]});
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        test_done;
    end
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; source_in = 32'h0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0, 4'h0);
            check(rd, 32'h0);
        end
        $display("test reset_values done");
        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 4; k++) begin
                w = $random(seed);
                if (i < 2) w[4:0] = {5{i[0]}};
                code[k] = w[4:0];
                apb(1'b1, 12'(4 * k), w, 4'hf);
            end
            w = $random(seed);
            gen = (i == 2) ? 8'hff : w[7:0];
            pol = w[8];
            apb(1'b1, 12'h010, {w[31:8], gen}, 4'h1);
            apb(1'b1, 12'h014, {w[31:9], pol, w[7:1], pol}, 4'h1);
            src = $random(seed);
            source_in <= src;
            repeat (8) @(posedge mclk);
            check(d1, src[code[0]]);
            check(d2, src[code[1]]);
            check(d3, src[code[2]]);
            check(d4, src[code[3]]);
            ex = gate_of(gen, {src[code[3]], src[code[2]], src[code[1]],
                src[code[0]]});
            check(g_out, ex);
            check(g_core, ex ^ pol);
            for (int k = 0; k < 4; k++) begin
                apb(1'b0, 12'(4 * k), 32'h0, 4'h0);
                check(rd, {27'h0, code[k]});
            end
            apb(1'b0, 12'h010, 32'h0, 4'h0);
            check(rd, {24'h0, gen});
            apb(1'b0, 12'h014, 32'h0, 4'h0);
            check(rd, {31'h0, pol});
            apb(1'b0, 12'h018, 32'h0, 4'h0);
            check(rd, {26'h0, ex ^ pol, ex, src[code[3]], src[code[2]],
                src[code[1]], src[code[0]]});
        end
        $display("test random_select done");
        apb(1'b1, 12'h000, {27'h0, ~code[0]}, 4'he);
        apb(1'b0, 12'h000, 32'h0, 4'h0);
        check(rd, {27'h0, code[0]});
        apb(1'b0, 12'h01c, 32'h0, 4'h0);
        check({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h018, 32'hff, 4'hf);
        check(er, 1'b1);
        $display("test refused_access done");
        test_done;
    end
endmodule // testbench
`default_nettype wire
